//--- include/host_pin_defines.svh
// Timing counts, field widths and reset values of the host pin logic
`ifndef HOST_PIN_DEFINES_SVH
`define HOST_PIN_DEFINES_SVH
`define CLK_PERIOD_NS 5
`define RST_FILTER_NS 100
`define RST_FILTER_CYC ((`RST_FILTER_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define EE_PERIOD_NS 4000
`define EE_HALF_CYC ((`EE_PERIOD_NS / 2) / `CLK_PERIOD_NS)
`define IRQ_SEL_W 2
`define EE_LEN_W 6
`define TX_LED_HOLD_CYC 20'h186A0
// Idle pin levels loaded into both synchroniser stages at reset
`define PIN_SYNC_IDLE 35'h1F7700000
// Cycles after reset release until the synchronisers carry pin levels
`define SYNC_SETTLE_CYC 2'h3
`endif

//--- include/host_pin_pkg.sv
// Types shared by the host pin logic
package host_pin_pkg;
    typedef struct packed {
        logic [15:0] addr;
        logic byteHighN;
    } latched_addr_t;
    typedef struct packed {
        logic select;
        logic dataToMem;
        logic shiftClock;
    } eeprom_pins_t;
    typedef enum logic [1:0] {
        EE_IDLE = 2'b00,
        EE_LOW = 2'b01,
        EE_HIGH = 2'b10,
        EE_DONE = 2'b11
    } ee_state_t;
endpackage

//--- hdl/eeprom_shifter.sv
// Serial EEPROM shift engine with 4 us shift clock
`timescale 1ns/1ps
`include "host_pin_defines.svh"
module eeprom_shifter (
    // Clock and reset
    input wire logic mclk,
    input wire logic resetn,
    // Command
    input wire logic start,
    input wire logic [31:0] txWord,
    input wire logic [`EE_LEN_W-1:0] bitCount,
    output logic busy,
    output logic [31:0] rxWord,
    // Pins
    input wire logic dataFromMemSync,
    output host_pin_pkg::eeprom_pins_t pins
);
    localparam int HALF = `EE_HALF_CYC;
    host_pin_pkg::ee_state_t state_q;
    logic [8:0] div_q;
    logic [`EE_LEN_W-1:0] left_q;
    logic [31:0] sh_q;
    wire halfTick = (div_q == 9'(HALF - 1));
    wire lastBit = (left_q == '0);
    assign busy = (state_q != host_pin_pkg::EE_IDLE);

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            state_q <= host_pin_pkg::EE_IDLE;
            div_q <= 9'h000;
            left_q <= '0;
            sh_q <= 32'h00000000;
            rxWord <= 32'h00000000;
            pins <= '0;
        end else begin
            div_q <= (halfTick || !busy) ? 9'h000 : div_q + 9'h001;
            case (state_q)
                host_pin_pkg::EE_IDLE: begin
                    pins.shiftClock <= 1'b0;
                    if (start && bitCount != '0) begin
                        sh_q <= txWord;
                        left_q <= bitCount - `EE_LEN_W'(1);
                        pins.select <= 1'b1;
                        pins.dataToMem <= txWord[31];
                        state_q <= host_pin_pkg::EE_LOW;
                    end
                end
                host_pin_pkg::EE_LOW: if (halfTick) begin
                    pins.shiftClock <= 1'b1;
                    sh_q <= {sh_q[30:0], dataFromMemSync};
                    state_q <= host_pin_pkg::EE_HIGH;
                end
                host_pin_pkg::EE_HIGH: if (halfTick) begin
                    pins.shiftClock <= 1'b0;
                    pins.dataToMem <= sh_q[31];
                    if (lastBit) begin
                        state_q <= host_pin_pkg::EE_DONE;
                    end else begin
                        left_q <= left_q - `EE_LEN_W'(1);
                        state_q <= host_pin_pkg::EE_LOW;
                    end
                end
                host_pin_pkg::EE_DONE: if (halfTick) begin
                    pins.select <= 1'b0;
                    pins.dataToMem <= 1'b0;
                    rxWord <= sh_q;
                    state_q <= host_pin_pkg::EE_IDLE;
                end
                default: state_q <= host_pin_pkg::EE_IDLE;
            endcase
        end
    end
endmodule

//--- hdl/host_pin_logic.sv
// Host-side pin logic for an ISA or PCMCIA network controller
// Summary of operation
// - Reset pin counts only after staying high 100 ns; powerdown bypasses the filter.
// - ISA: address and byte-high enable latched on falling address latch strobe.
// - PCMCIA: card write strobe writes option, status registers and attribute memory.
// - ISA: drive only the selected interrupt line high; others float.
// - PCMCIA: single active-low interrupt request output replaces ISA lines.
// - PCMCIA: input acknowledge asserted on reads while card enabled.
// - ISA: wide I/O indicator when 16-bit, address enable low, A4-A15 match base.
// - PCMCIA: wide I/O indicator when 16-bit, config enable high, space select low.
// - Memory read strobe reads boot ROM in ISA, attribute space in PCMCIA.
// - EEPROM shift clock has a 4 us period.
// - EEPROM select driven during EEPROM accesses.
// - Data out to EEPROM input; data sampled from EEPROM output.
// - Three switch inputs choose EEPROM sets and are readable.
// - Shared pin: transmit LED with internal codec, active-low enable with external.
// - Mode pin sampled at reset end: low means PCMCIA, high means ISA.
// - ISA address decode only while address enable is low.
// - Codec strap low selects external codec, open selects internal.
// - Bus-width strap low gives 16-bit bus, open gives 8-bit.
`timescale 1ns/1ps
`include "host_pin_defines.svh"
module host_pin_logic (
    // Clock and reset
    input wire logic mclk,
    input wire logic resetn,
    // Reset and straps
    input wire logic resetPin,
    input wire logic powerDown,
    input wire logic romSelectOrCardModeN,
    input wire logic extCodecStrapN,
    input wire logic wideBusStrapN,
    output logic deviceReset,
    output logic cardMode,
    output logic extCodec,
    output logic wideBus,
    // Host bus pins
    input wire logic [19:0] hostAddr,
    input wire logic addrEnableOrRegN,
    input wire logic byteHighN,
    input wire logic addressLatchStrobeOrWriteN,
    input wire logic ioReadStrobeN,
    input wire logic ioWriteStrobeN,
    input wire logic romReadStrobeOrOutputEnableN,
    // Interrupt and indicator pins
    output logic [3:0] isaIrqLinesOut,
    output logic [3:0] isaIrqLinesOe,
    output logic cardIrqRequestN,
    output logic cardInputAckN,
    output logic wideIoIndicatorOut,
    output logic wideIoIndicatorOe,
    // Core side
    input wire logic coreIrq,
    input wire logic [1:0] irqLineSelect,
    input wire logic configEnableBit,
    input wire logic [7:0] baseAddrHigh,
    output host_pin_pkg::latched_addr_t latchedAddr,
    output logic hostIoRead,
    output logic hostIoWrite,
    output logic hostMemRead,
    output logic cardAttrWrite,
    // EEPROM
    input wire logic eeStart,
    input wire logic [31:0] eeTxWord,
    input wire logic [`EE_LEN_W-1:0] eeBitCount,
    output logic eeBusy,
    output logic [31:0] eeRxWord,
    input wire logic eepromDataFromMem,
    output host_pin_pkg::eeprom_pins_t eepromPins,
    // Switches and transmit indicator
    input wire logic [2:0] configSwitchInputs,
    output logic [2:0] configSwitchLevels,
    input wire logic coreTxActive,
    output logic transmitIndicatorOut,
    output logic transmitIndicatorOe
);
    // Two-stage synchronisers for every pin input
    localparam int SW = 35;
    logic [SW-1:0] s1_q, s2_q;
    wire [SW-1:0] rawPins = {
        resetPin,
        powerDown,
        romSelectOrCardModeN,
        extCodecStrapN,
        wideBusStrapN,
        addrEnableOrRegN,
        byteHighN,
        addressLatchStrobeOrWriteN,
        ioReadStrobeN,
        ioWriteStrobeN,
        romReadStrobeOrOutputEnableN,
        eepromDataFromMem,
        configSwitchInputs,
        hostAddr
    };
    // Idle levels keep strobes quiet until real pin levels arrive
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            s1_q <= `PIN_SYNC_IDLE;
            s2_q <= `PIN_SYNC_IDLE;
        end else begin
            s1_q <= rawPins;
            s2_q <= s1_q;
        end
    end
    wire rstS = s2_q[34];
    wire pdS = s2_q[33];
    wire modeS = s2_q[32];
    wire codecS = s2_q[31];
    wire widthS = s2_q[30];
    wire aenS = s2_q[29];
    wire bheS = s2_q[28];
    wire aleS = s2_q[27];
    wire iordS = s2_q[26];
    wire iowrS = s2_q[25];
    wire memrS = s2_q[24];
    wire eeDinS = s2_q[23];
    wire [2:0] swS = s2_q[22:20];
    wire [19:0] addrS = s2_q[19:0];

    // Reset glitch filter
    localparam int RCYC = `RST_FILTER_CYC;
    logic [4:0] rstCnt_q;
    logic [1:0] settle_q;
    logic aleLast_q;
    wire rstLong = (rstCnt_q >= 5'(RCYC));
    wire settled = (settle_q == `SYNC_SETTLE_CYC);
    // Counter saturates once the pulse is long enough
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            rstCnt_q <= 5'h00;
            settle_q <= 2'h0;
            deviceReset <= 1'b1;
        end else begin
            rstCnt_q <= !rstS ? 5'h00 : (rstLong ? rstCnt_q : rstCnt_q + 5'h01);
            settle_q <= settled ? settle_q : settle_q + 2'h1;
            // Reset stands until the synchronisers carry the strap levels
            deviceReset <= !settled || (pdS ? rstS : rstLong);
        end
    end

    // Straps read while reset stands, last sample kept
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            cardMode <= 1'b0;
            extCodec <= 1'b0;
            wideBus <= 1'b0;
        end else if (deviceReset) begin
            cardMode <= !modeS;
            extCodec <= !codecS;
            wideBus <= !widthS;
        end
    end

    // ISA address latch and strobes
    wire isa = !cardMode;
    wire aleFall = aleLast_q && !aleS;
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            aleLast_q <= 1'b0;
            latchedAddr <= '0;
        end else begin
            aleLast_q <= aleS;
            if (isa && aleFall) begin
                latchedAddr <= '{addr: addrS[15:0], byteHighN: bheS};
            end
        end
    end
    wire isaDecode = isa && !aenS;
    // A4-A7 must be zero, A8-A15 compare against the base high byte
    wire baseMatch = (addrS[15:8] == baseAddrHigh) && (addrS[7:4] == 4'h0);
    wire cardIoSel = cardMode && !aenS && configEnableBit;
    assign hostIoRead = !iordS && (isaDecode || cardIoSel);
    assign hostIoWrite = !iowrS && (isaDecode || cardIoSel);
    assign hostMemRead = !memrS;
    assign cardAttrWrite = cardMode && !aleS;

    // Interrupts; unselected ISA lines float
    assign isaIrqLinesOut = isa ? (4'h1 << irqLineSelect) & {4{coreIrq}} : 4'h0;
    assign isaIrqLinesOe = isa ? (4'h1 << irqLineSelect) : 4'h0;
    assign cardIrqRequestN = !(cardMode && coreIrq);
    assign cardInputAckN = !(cardMode && cardIoSel && !iordS);

    // Wide I/O indicator, open drain
    wire isaWide = isa && wideBus && isaDecode && baseMatch;
    wire cardWide = cardMode && wideBus && configEnableBit && !aenS;
    assign wideIoIndicatorOut = 1'b0;
    assign wideIoIndicatorOe = isaWide || cardWide;

    // EEPROM engine
    eeprom_shifter eeEngine (
        .mclk(mclk),
        .resetn(resetn),
        .start(eeStart),
        .txWord(eeTxWord),
        .bitCount(eeBitCount),
        .busy(eeBusy),
        .rxWord(eeRxWord),
        .dataFromMemSync(eeDinS),
        .pins(eepromPins)
    );

    assign configSwitchLevels = swS;

    // Transmit LED stretch or external codec enable
    logic [19:0] ledHold_q;
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            ledHold_q <= 20'h00000;
        end else begin
            ledHold_q <= coreTxActive ? `TX_LED_HOLD_CYC :
                (ledHold_q != 20'h00000 ? ledHold_q - 20'h00001 : 20'h00000);
        end
    end
    // External codec: enable follows activity; internal: stretched LED pulls low
    assign transmitIndicatorOut = extCodec ? !coreTxActive : 1'b0;
    assign transmitIndicatorOe = extCodec ? 1'b1 : (ledHold_q != 20'h00000);
endmodule

//--- verification/host_pin_chk.sv
// Concurrent checks on the host pin logic ports
`timescale 1ns/1ps
`include "host_pin_defines.svh"
module host_pin_chk (
    // Clock and reset
    input wire logic mclk,
    input wire logic resetn,
    // Watched ports
    input wire logic resetPin,
    input wire logic powerDown,
    input wire logic addrEnableOrRegN,
    input wire logic coreIrq,
    input wire logic [1:0] irqLineSelect,
    input wire logic cardMode,
    input wire logic extCodec,
    input wire logic deviceReset,
    input wire logic [3:0] isaIrqLinesOut,
    input wire logic [3:0] isaIrqLinesOe,
    input wire logic cardIrqRequestN,
    input wire logic wideIoIndicatorOe,
    input wire logic eeBusy,
    input wire host_pin_pkg::eeprom_pins_t eepromPins,
    input wire logic coreTxActive,
    input wire logic transmitIndicatorOut
);
    localparam int HALF = `EE_HALF_CYC;
    logic [15:0] cnt_q;
    logic [7:0] hi_q;
    logic [1:0] prev_q;
    wire [1:0] chg = {eepromPins.select, eepromPins.shiftClock} ^ prev_q;
    // Cycles since last pin change, run of high reset pin
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            cnt_q <= 16'h0000;
            hi_q <= 8'h00;
            prev_q <= 2'h0;
        end else begin
            cnt_q <= (chg != 2'h0) ? 16'h0000 : cnt_q + 16'h0001;
            hi_q <= !resetPin ? 8'h00 : hi_q + {7'h00, hi_q != 8'hFF};
            prev_q <= {eepromPins.select, eepromPins.shiftClock};
        end
    end
    default clocking @(posedge mclk); endclocking
    default disable iff (!resetn);
    a_irq_sel_only: assert property (!cardMode |-> isaIrqLinesOe == (4'h1 << irqLineSelect))
        else $error("unselected interrupt line enabled");
    a_irq_line_level: assert property (!cardMode |-> isaIrqLinesOut[irqLineSelect] == coreIrq)
        else $error("selected interrupt line level wrong");
    a_card_irq_low: assert property (cardMode |-> cardIrqRequestN == !coreIrq && isaIrqLinesOe == 4'h0)
        else $error("card interrupt request wrong");
    a_decode_gate_off: assert property ($past(resetn, 3) && $past(addrEnableOrRegN, 2)
        && $past(addrEnableOrRegN, 3) |-> !wideIoIndicatorOe)
        else $error("wide indicator without address qualifier");
    a_reset_glitch_filter: assert property (!powerDown && $rose(deviceReset) |-> hi_q >= 8'(`RST_FILTER_CYC))
        else $error("short reset pulse accepted");
    a_ee_half_period: assert property (chg[0] || (chg[1] && !eepromPins.select) |-> cnt_q == HALF - 1)
        else $error("eeprom clock half period wrong");
    a_ee_clock_select: assert property (eepromPins.shiftClock |-> eepromPins.select)
        else $error("eeprom clock outside select");
    a_ee_busy_select: assert property (eeBusy == eepromPins.select)
        else $error("eeprom select does not track access");
    a_tx_enable_low: assert property (extCodec |-> transmitIndicatorOut == !coreTxActive)
        else $error("external transmit enable wrong");
    c_ee_done: cover property ($fell(eeBusy));
    c_reset_taken: cover property ($rose(deviceReset));
    c_card_irq: cover property (cardMode && !cardIrqRequestN);
endmodule
bind host_pin_logic host_pin_chk host_pin_chk_i (.mclk, .resetn, .resetPin, .powerDown,
    .addrEnableOrRegN, .coreIrq, .irqLineSelect, .cardMode, .extCodec, .deviceReset,
    .isaIrqLinesOut, .isaIrqLinesOe, .cardIrqRequestN, .wideIoIndicatorOe, .eeBusy,
    .eepromPins, .coreTxActive, .transmitIndicatorOut);

//--- verification/eeprom_model.sv
// Serial EEPROM stand-in at the far side of the shift pins
`timescale 1ns/1ps
module eeprom_model (
    // Pins and reply
    input wire host_pin_pkg::eeprom_pins_t pins,
    input wire logic [7:0] reply,
    output logic [7:0] got,
    output logic dataFromMem
);
    logic [3:0] n = 4'h0;
    initial got = 8'h00;
    always @(posedge pins.select) n = 4'h0;
    // Next reply bit after each falling clock
    always @(negedge pins.shiftClock) n = n + 4'h1;
    always @(posedge pins.shiftClock) if (pins.select) got <= {got[6:0], pins.dataToMem};
    // Released line sits at the pull-down level
    assign dataFromMem = (pins.select && n < 4'h8) ? reply[3'h7 - n[2:0]] : 1'b0;
endmodule

//--- verification/host_pin_logic_tb_top.sv
// Self-checking bench for the host pin logic
`timescale 1ns/1ps
`include "host_pin_defines.svh"
module host_pin_logic_tb_top;
    typedef struct packed {logic [1:0] sel; logic irq; logic [3:0] oe;} irq_row_t;
    irq_row_t rows [4] = '{'{2'h0, 1'b1, 4'h1}, '{2'h1, 1'b0, 4'h2}, '{2'h2, 1'b1, 4'h4},
        '{2'h3, 1'b1, 4'h8}};
    logic mclk = 1'b0, resetn = 1'b0, resetPin = 1'b0, powerDown = 1'b0;
    logic romSelectOrCardModeN = 1'b1, extCodecStrapN = 1'b1, wideBusStrapN = 1'b0;
    logic [19:0] hostAddr = 20'h00000;
    logic addrEnableOrRegN = 1'b1, byteHighN = 1'b1, addressLatchStrobeOrWriteN = 1'b0;
    logic ioReadStrobeN = 1'b1, ioWriteStrobeN = 1'b1, romReadStrobeOrOutputEnableN = 1'b1;
    logic coreIrq = 1'b0, configEnableBit = 1'b0, eeStart = 1'b0, coreTxActive = 1'b0;
    logic [1:0] irqLineSelect = 2'h0;
    logic [7:0] baseAddrHigh = 8'h00, eeGot;
    logic [31:0] eeTxWord = 32'h00000000, eeRxWord;
    logic [`EE_LEN_W-1:0] eeBitCount = '0;
    logic [2:0] configSwitchInputs = 3'h0, configSwitchLevels;
    logic deviceReset, cardMode, extCodec, wideBus, cardIrqRequestN, cardInputAckN;
    logic wideIoIndicatorOut, wideIoIndicatorOe, hostIoRead, hostIoWrite, hostMemRead;
    logic cardAttrWrite, eeBusy, eepromDataFromMem, transmitIndicatorOut, transmitIndicatorOe;
    logic [3:0] isaIrqLinesOut, isaIrqLinesOe;
    host_pin_pkg::latched_addr_t latchedAddr;
    host_pin_pkg::eeprom_pins_t eepromPins;
    int err_count = 0, tests_run = 0;
    always #2.5 mclk = ~mclk;
    host_pin_logic host_pin_logic_i (.mclk, .resetn, .resetPin, .powerDown, .romSelectOrCardModeN,
        .extCodecStrapN, .wideBusStrapN, .deviceReset, .cardMode, .extCodec, .wideBus, .hostAddr,
        .addrEnableOrRegN, .byteHighN, .addressLatchStrobeOrWriteN, .ioReadStrobeN,
        .ioWriteStrobeN, .romReadStrobeOrOutputEnableN, .isaIrqLinesOut, .isaIrqLinesOe,
        .cardIrqRequestN, .cardInputAckN, .wideIoIndicatorOut, .wideIoIndicatorOe, .coreIrq,
        .irqLineSelect, .configEnableBit, .baseAddrHigh, .latchedAddr, .hostIoRead, .hostIoWrite,
        .hostMemRead, .cardAttrWrite, .eeStart, .eeTxWord, .eeBitCount, .eeBusy, .eeRxWord,
        .eepromDataFromMem, .eepromPins, .configSwitchInputs, .configSwitchLevels, .coreTxActive,
        .transmitIndicatorOut, .transmitIndicatorOe);
    eeprom_model eeprom_model_i (.pins(eepromPins), .reply(8'h3C), .got(eeGot),
        .dataFromMem(eepromDataFromMem));
    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_count++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic results;
        $display("mismatches %0d, comparisons %0d", err_count, tests_run);
        if (err_count == 0 && tests_run > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    // Long reset pin pulse so the straps are taken again
    task automatic strapReset(input logic r, input logic c);
        romSelectOrCardModeN = r;
        extCodecStrapN = c;
        resetPin = 1'b1;
        tick(30);
        chk(deviceReset, 1'b1);
        resetPin = 1'b0;
        tick(30);
    endtask
    initial begin
        #150000;
        err_count++;
        results();
    end
    initial begin
        tick(5);
        resetn = 1'b1;
        tick(4);
        chk({cardMode, extCodec, wideBus}, 3'h1);
        foreach (rows[i]) begin
            irqLineSelect = rows[i].sel;
            coreIrq = rows[i].irq;
            tick(1);
            chk(isaIrqLinesOe, rows[i].oe);
            chk(isaIrqLinesOut[rows[i].sel], rows[i].irq);
        end
        hostAddr = 20'h0ABCD;
        byteHighN = 1'b0;
        addressLatchStrobeOrWriteN = 1'b1;
        tick(4);
        addressLatchStrobeOrWriteN = 1'b0;
        tick(4);
        hostAddr = 20'h0AB00;
        byteHighN = 1'b1;
        baseAddrHigh = 8'hAB;
        addrEnableOrRegN = 1'b0;
        tick(4);
        chk(latchedAddr, {16'hABCD, 1'b0});
        chk({wideIoIndicatorOe, wideIoIndicatorOut}, 2'h2);
        for (int i = 0; i < 2; i++) begin
            {ioReadStrobeN, ioWriteStrobeN} = ~(2'h2 >> i);
            tick(4);
            chk({hostIoRead, hostIoWrite}, 2'h2 >> i);
        end
        {ioReadStrobeN, ioWriteStrobeN} = 2'h3;
        romReadStrobeOrOutputEnableN = 1'b0;
        hostAddr = 20'h0AB10;
        configSwitchInputs = 3'h5;
        tick(4);
        chk(wideIoIndicatorOe, 1'b0);
        chk(configSwitchLevels, 3'h5);
        chk(hostMemRead, 1'b1);
        hostAddr = 20'h0AB00;
        addrEnableOrRegN = 1'b1;
        romReadStrobeOrOutputEnableN = 1'b1;
        resetPin = 1'b1;
        tick(10);
        resetPin = 1'b0;
        tick(4);
        chk({wideIoIndicatorOe, deviceReset}, 2'h0);
        chk(hostMemRead, 1'b0);
        powerDown = 1'b1;
        resetPin = 1'b1;
        tick(4);
        chk(deviceReset, 1'b1);
        resetPin = 1'b0;
        tick(4);
        powerDown = 1'b0;
        eeTxWord = 32'hA5000000;
        eeBitCount = 6'h08;
        eeStart = 1'b1;
        tick(1);
        eeStart = 1'b0;
        tick(1);
        chk(eepromPins.select, 1'b1);
        for (int k = 0; k < 8000 && eeBusy !== 1'b0; k++) tick(1);
        chk(eeBusy, 1'b0);
        chk({eeRxWord[7:0], eeGot}, 16'h3CA5);
        strapReset(1'b1, 1'b0);
        chk(extCodec, 1'b1);
        coreTxActive = 1'b1;
        tick(1);
        chk(transmitIndicatorOut, 1'b0);
        addressLatchStrobeOrWriteN = 1'b1;
        strapReset(1'b0, 1'b1);
        chk(cardMode, 1'b1);
        chk({transmitIndicatorOut, transmitIndicatorOe}, 2'h1);
        coreIrq = 1'b1;
        addrEnableOrRegN = 1'b0;
        configEnableBit = 1'b1;
        ioReadStrobeN = 1'b0;
        tick(4);
        chk({cardIrqRequestN, cardInputAckN, wideIoIndicatorOe}, 3'h1);
        ioReadStrobeN = 1'b1;
        addressLatchStrobeOrWriteN = 1'b0;
        tick(4);
        chk(cardAttrWrite, 1'b1);
        configEnableBit = 1'b0;
        tick(4);
        chk(wideIoIndicatorOe, 1'b0);
        results();
    end
endmodule
